// [include/laser_cfg_pkg.sv]
// Register map, field layout, reset values and range tables of the channel configuration block
package laser_cfg_pkg;
    localparam int CHANNELS = 2;
    localparam int CUR_W = 21;
    localparam logic [7:0] ADDR_CH1_CTRL = 8'h10;
    localparam logic [7:0] ADDR_CH1_THRESH = 8'h11;
    localparam logic [7:0] ADDR_CH2_CTRL = 8'h15;
    localparam logic [7:0] ADDR_CH2_THRESH = 8'h16;
    localparam logic [7:0] ADDR_RANGE = 8'h1a;
    localparam logic [7:0] ADDR_SIM = 8'h1d;
    localparam logic [7:0] ADDR_SUBRANGE = 8'h1e;
    localparam int MODE_BIT = 0;
    localparam int DISABLE_BIT = 3;
    localparam int SOURCE_LSB = 5;
    localparam int RANGE_CH1_BIT = 0;
    localparam int MEAS_CH1_BIT = 1;
    localparam int RANGE_CH2_BIT = 4;
    localparam int MEAS_CH2_BIT = 5;
    localparam int SIM_CH1_BIT = 5;
    localparam int SIM_CH2_BIT = 6;
    localparam int SUB_CH1_LSB = 0;
    localparam int SUB_CH2_LSB = 4;
    localparam logic MODE_RST = 1'b0;
    localparam logic DISABLE_RST = 1'b1;
    localparam logic [2:0] SOURCE_RST = 3'h0;
    localparam logic [7:0] THRESH_RST = 8'hff;
    localparam logic RANGE_RST = 1'b0;
    localparam logic MEAS_RST = 1'b0;
    localparam logic SIM_RST = 1'b0;
    localparam logic [1:0] SUB_RST = 2'h0;
    localparam logic [2:0] SOURCE_CURRENT = 3'h4;
    // Range factor k is K_NUM / K_DEN
    localparam logic [9:0] K_DEN = 10'h2ee;
    localparam logic [9:0] K_NUM [4] = '{10'h2ee, 10'h064, 10'h019, 10'h009};
    // Threshold step 0.375 mA low range, 3 mA high range; limits are in 0.5 uA units
    localparam int STEP_HIGH_SHIFT = 3;
    // Full-scale current in 0.1 mA units, index {sense range bit, subrange field}
    localparam logic [13:0] FULL_SCALE [8] = '{14'h1d4c, 14'h03e8, 14'h00fa, 14'h005a,
                                               14'h0384, 14'h0078, 14'h001e, 14'h000b};
endpackage : laser_cfg_pkg

// [include/chan_cfg_if.sv]
// Per-channel configuration and derived threshold carried between the channel modules
`timescale 1ns/1ps
interface chan_cfg_if;
    logic mode;
    logic range_low;
    logic [1:0] subrange;
    logic [7:0] threshold;
    logic sim;
    logic disable_bit;
    logic linear;
    logic [laser_cfg_pkg::CUR_W-1:0] limit;
    logic protect_on;
    modport cfg (output mode, range_low, subrange, threshold, sim, disable_bit, linear,
                 input limit, protect_on);
    modport calc (input mode, range_low, subrange, threshold, linear,
                  output limit, protect_on);
    modport guard (input sim, disable_bit, limit, protect_on);
endinterface : chan_cfg_if

// [core/overcurrent_limit.sv]
// Overcurrent threshold and protection enable for one channel
`timescale 1ns/1ps
module overcurrent_limit (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    chan_cfg_if.calc cfg
);
    logic [17:0] product;
    logic [laser_cfg_pkg::CUR_W-1:0] next_limit;
    logic next_protect;

    always_comb begin
        product = cfg.threshold * laser_cfg_pkg::K_NUM[cfg.subrange];
        if (cfg.range_low) begin
            next_limit = {3'h0, product}; // R06 R07
        end else begin
            next_limit = {product, 3'h0}; // R06 R07
        end
        // Zero threshold only switches protection off in current regulation
        next_protect = !cfg.linear && !(cfg.mode && cfg.threshold == 8'h00); // R08 R09 R11
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg.limit <= '0;
        end else begin
            cfg.limit <= next_limit;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg.protect_on <= 1'b0;
        end else begin
            cfg.protect_on <= next_protect;
        end
    end
endmodule : overcurrent_limit

// [core/channel_guard.sv]
// Overcurrent trip, error flag and channel enable for one channel
`timescale 1ns/1ps
module channel_guard (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    chan_cfg_if.guard cfg,
    input wire logic [laser_cfg_pkg::CUR_W-1:0] current_i,
    input wire logic enable_pin_i,
    output logic flag_o,
    output logic active_o
);
    logic latched;
    logic over;
    logic next_latched;

    always_comb begin
        over = cfg.protect_on && (current_i > cfg.limit); // R12
        // Set wins over the clear; a real trip holds until the pin is cycled low
        next_latched = over || (latched && enable_pin_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            latched <= 1'b0;
        end else begin
            latched <= next_latched;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= next_latched || cfg.sim; // R13 R14
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            active_o <= 1'b0;
        end else begin
            active_o <= enable_pin_i && !cfg.disable_bit && !next_latched
                && !cfg.sim; // R12 R13 R17
        end
    end
endmodule : channel_guard

// [core/laser_channel_regulation_config.sv]
// Dual channel regulation configuration registers with overcurrent protection
//
// Notes on behaviour
// (R01) Mode bit 0 power, 1 current regulation
// (R02) Current mode routes feedback through sense resistor
// (R03) Range bit: 0 high 2k, 1 low 16k
// (R04) Subrange field picks factor k per code
// (R05) Subrange and range bit give full-scale current
// (R06) Threshold limit is step times n times k
// (R07) Step 0.375 mA low range, 3 mA high
// (R08) Zero threshold disables protection in current mode
// (R09) Zero threshold in power mode means minimum
// (R10) Threshold 0xff, also reset, is maximum
// (R11) Linear reference coding turns protection off
// (R12) Current above threshold disables the channel
// (R13) Simulation bit sets flag, check, disable
// (R14) Simulated fault holds while simulation bit set
// (R15) Reference code 10 bits, log or linear
// (R16) Software selects current source for measurement
// (R17) Disabled when pin low or disable bit
`timescale 1ns/1ps
module laser_channel_regulation_config #(
    parameter int CUR_W = laser_cfg_pkg::CUR_W
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [1:0] channel_enable_pin_i,
    input wire logic [1:0] reference_coding_select_i,
    input wire logic [1:0][9:0] reference_code_i,
    input wire logic [1:0][CUR_W-1:0] laser_current_i,
    output logic [1:0] current_regulation_o,
    output logic [1:0] sense_resistor_route_o,
    output logic [1:0] sense_range_low_o,
    output logic [1:0][9:0] range_factor_num_o,
    output logic [1:0][13:0] full_scale_o,
    output logic [1:0][CUR_W-1:0] threshold_limit_o,
    output logic [1:0] protection_active_o,
    output logic [1:0] overcurrent_error_flag_o,
    output logic fault_check_output_n_o,
    output logic [1:0] channel_active_o,
    output logic [1:0][9:0] dac_code_o,
    output logic [1:0] dac_linear_o,
    output logic [1:0][2:0] converter_source_o,
    output logic [1:0] current_measure_select_o,
    output logic [1:0] current_measure_ready_o
);
    generate
        if (CUR_W != laser_cfg_pkg::CUR_W) begin : g_width_check
            $error("CUR_W must match the threshold arithmetic width");
        end
    endgenerate

    logic [1:0] mode;
    logic [1:0] disable_bit;
    logic [1:0][2:0] source;
    logic [1:0][7:0] threshold;
    logic [1:0] range_low;
    logic [1:0] meas;
    logic [1:0] sim;
    logic [1:0][1:0] subrange;
    logic [7:0] next_rdata;

    chan_cfg_if cfg_bus [2] ();

    // Channel control words: mode, disable and converter source
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mode <= {2{laser_cfg_pkg::MODE_RST}};
            disable_bit <= {2{laser_cfg_pkg::DISABLE_RST}};
            source <= {2{laser_cfg_pkg::SOURCE_RST}};
        end else if (reg_wr_i) begin
            if (reg_addr_i == laser_cfg_pkg::ADDR_CH1_CTRL) begin
                mode[0] <= reg_wdata_i[laser_cfg_pkg::MODE_BIT]; // R01
                disable_bit[0] <= reg_wdata_i[laser_cfg_pkg::DISABLE_BIT]; // R17
                source[0] <= reg_wdata_i[laser_cfg_pkg::SOURCE_LSB +: 3];
            end
            if (reg_addr_i == laser_cfg_pkg::ADDR_CH2_CTRL) begin
                mode[1] <= reg_wdata_i[laser_cfg_pkg::MODE_BIT]; // R01
                disable_bit[1] <= reg_wdata_i[laser_cfg_pkg::DISABLE_BIT]; // R17
                source[1] <= reg_wdata_i[laser_cfg_pkg::SOURCE_LSB +: 3];
            end
        end
    end

    // Thresholds come out of reset at the maximum setting
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            threshold <= {2{laser_cfg_pkg::THRESH_RST}}; // R10
        end else if (reg_wr_i) begin
            if (reg_addr_i == laser_cfg_pkg::ADDR_CH1_THRESH) begin
                threshold[0] <= reg_wdata_i; // R06
            end
            if (reg_addr_i == laser_cfg_pkg::ADDR_CH2_THRESH) begin
                threshold[1] <= reg_wdata_i; // R06
            end
        end
    end

    // Shared range word holds both channels' range and measurement bits
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            range_low <= {2{laser_cfg_pkg::RANGE_RST}};
            meas <= {2{laser_cfg_pkg::MEAS_RST}};
        end else if (reg_wr_i && reg_addr_i == laser_cfg_pkg::ADDR_RANGE) begin
            range_low[0] <= reg_wdata_i[laser_cfg_pkg::RANGE_CH1_BIT]; // R03
            range_low[1] <= reg_wdata_i[laser_cfg_pkg::RANGE_CH2_BIT]; // R03
            meas[0] <= reg_wdata_i[laser_cfg_pkg::MEAS_CH1_BIT];
            meas[1] <= reg_wdata_i[laser_cfg_pkg::MEAS_CH2_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sim <= {2{laser_cfg_pkg::SIM_RST}};
        end else if (reg_wr_i && reg_addr_i == laser_cfg_pkg::ADDR_SIM) begin
            sim[0] <= reg_wdata_i[laser_cfg_pkg::SIM_CH1_BIT]; // R13 R14
            sim[1] <= reg_wdata_i[laser_cfg_pkg::SIM_CH2_BIT]; // R13 R14
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            subrange <= {2{laser_cfg_pkg::SUB_RST}};
        end else if (reg_wr_i && reg_addr_i == laser_cfg_pkg::ADDR_SUBRANGE) begin
            subrange[0] <= reg_wdata_i[laser_cfg_pkg::SUB_CH1_LSB +: 2]; // R04
            subrange[1] <= reg_wdata_i[laser_cfg_pkg::SUB_CH2_LSB +: 2]; // R04
        end
    end

    // Read back; bits not held here and unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            laser_cfg_pkg::ADDR_CH1_CTRL: begin
                next_rdata[laser_cfg_pkg::MODE_BIT] = mode[0];
                next_rdata[laser_cfg_pkg::DISABLE_BIT] = disable_bit[0];
                next_rdata[laser_cfg_pkg::SOURCE_LSB +: 3] = source[0];
            end
            laser_cfg_pkg::ADDR_CH2_CTRL: begin
                next_rdata[laser_cfg_pkg::MODE_BIT] = mode[1];
                next_rdata[laser_cfg_pkg::DISABLE_BIT] = disable_bit[1];
                next_rdata[laser_cfg_pkg::SOURCE_LSB +: 3] = source[1];
            end
            laser_cfg_pkg::ADDR_CH1_THRESH: begin
                next_rdata = threshold[0];
            end
            laser_cfg_pkg::ADDR_CH2_THRESH: begin
                next_rdata = threshold[1];
            end
            laser_cfg_pkg::ADDR_RANGE: begin
                next_rdata[laser_cfg_pkg::RANGE_CH1_BIT] = range_low[0];
                next_rdata[laser_cfg_pkg::RANGE_CH2_BIT] = range_low[1];
                next_rdata[laser_cfg_pkg::MEAS_CH1_BIT] = meas[0];
                next_rdata[laser_cfg_pkg::MEAS_CH2_BIT] = meas[1];
            end
            laser_cfg_pkg::ADDR_SIM: begin
                next_rdata[laser_cfg_pkg::SIM_CH1_BIT] = sim[0];
                next_rdata[laser_cfg_pkg::SIM_CH2_BIT] = sim[1];
            end
            laser_cfg_pkg::ADDR_SUBRANGE: begin
                next_rdata[laser_cfg_pkg::SUB_CH1_LSB +: 2] = subrange[0];
                next_rdata[laser_cfg_pkg::SUB_CH2_LSB +: 2] = subrange[1];
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // Reference converter setup is sampled so the analog side sees stable codes
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dac_code_o <= '0;
            dac_linear_o <= 2'h0;
        end else begin
            dac_code_o <= reference_code_i; // R15
            dac_linear_o <= reference_coding_select_i; // R15
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < laser_cfg_pkg::CHANNELS; ch++) begin : g_chan
            assign cfg_bus[ch].mode = mode[ch];
            assign cfg_bus[ch].range_low = range_low[ch];
            assign cfg_bus[ch].subrange = subrange[ch];
            assign cfg_bus[ch].threshold = threshold[ch];
            assign cfg_bus[ch].sim = sim[ch];
            assign cfg_bus[ch].disable_bit = disable_bit[ch];
            assign cfg_bus[ch].linear = reference_coding_select_i[ch];

            overcurrent_limit u_limit (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .cfg(cfg_bus[ch])
            );

            channel_guard u_guard (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .cfg(cfg_bus[ch]),
                .current_i(laser_current_i[ch]),
                .enable_pin_i(channel_enable_pin_i[ch]),
                .flag_o(overcurrent_error_flag_o[ch]),
                .active_o(channel_active_o[ch])
            );

            assign current_regulation_o[ch] = mode[ch]; // R01
            // The log monitor resistor is bypassed in current regulation
            assign sense_resistor_route_o[ch] = mode[ch]; // R02
            assign sense_range_low_o[ch] = range_low[ch]; // R03
            assign range_factor_num_o[ch] = laser_cfg_pkg::K_NUM[subrange[ch]]; // R04
            assign full_scale_o[ch]
                = laser_cfg_pkg::FULL_SCALE[{range_low[ch], subrange[ch]}]; // R05
            assign threshold_limit_o[ch] = cfg_bus[ch].limit;
            assign protection_active_o[ch] = cfg_bus[ch].protect_on;
            assign converter_source_o[ch] = source[ch];
            assign current_measure_select_o[ch] = meas[ch];
            // Flags the setup software needs for a current reading in power mode
            assign current_measure_ready_o[ch] = !mode[ch] && meas[ch]
                && source[ch] == laser_cfg_pkg::SOURCE_CURRENT; // R16
        end
    endgenerate

    // Check output is low while any error flag stands
    assign fault_check_output_n_o = ~|overcurrent_error_flag_o; // R13

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_sim_flag;
        sim[0] |=> overcurrent_error_flag_o[0] && !fault_check_output_n_o;
    endproperty
    a_sim_flag: assert property (p_sim_flag) else $error("simulated fault not flagged"); // R13

    property p_sim_off;
        sim[1] |=> !channel_active_o[1];
    endproperty
    a_sim_off: assert property (p_sim_off) else $error("channel 2 on during simulation"); // R13

    property p_sim_hold;
        sim[0] [*3] |=> overcurrent_error_flag_o[0];
    endproperty
    a_sim_hold: assert property (p_sim_hold) else $error("simulated fault released early"); // R14

    property p_zero_current_mode;
        mode[0] && threshold[0] == 8'h00 |=> !protection_active_o[0];
    endproperty
    a_zero_current_mode: assert property (p_zero_current_mode) // R08
        else $error("zero threshold kept protection in current mode");

    property p_zero_power_mode;
        !mode[0] && !reference_coding_select_i[0] && threshold[0] == 8'h00
            |=> protection_active_o[0] && threshold_limit_o[0] == '0;
    endproperty
    a_zero_power_mode: assert property (p_zero_power_mode) // R09
        else $error("zero threshold not minimum in power mode");

    property p_limit_high;
        !range_low[0] && threshold[0] == 8'hff && subrange[0] == 2'h0
            |=> threshold_limit_o[0] == 21'h175890;
    endproperty
    a_limit_high: assert property (p_limit_high) // R06 R07 R10
        else $error("maximum high limit wrong");

    property p_limit_low;
        range_low[1] |=> threshold_limit_o[1] == CUR_W'($past(threshold[1]))
            * CUR_W'(laser_cfg_pkg::K_NUM[$past(subrange[1])]);
    endproperty
    a_limit_low: assert property (p_limit_low) else $error("low range limit wrong"); // R06 R07

    property p_linear_off;
        reference_coding_select_i[1] |=> !protection_active_o[1];
    endproperty
    a_linear_off: assert property (p_linear_off) // R11
        else $error("protection on with linear coding");

    property p_trip;
        protection_active_o[0] && laser_current_i[0] > threshold_limit_o[0]
            |=> !channel_active_o[0] && overcurrent_error_flag_o[0];
    endproperty
    a_trip: assert property (p_trip) else $error("overcurrent did not disable channel"); // R12

    property p_pin_off;
        !channel_enable_pin_i[0] || disable_bit[0] |=> !channel_active_o[0];
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("channel on while disabled"); // R17

    c_sim: cover property (sim[0] ##1 overcurrent_error_flag_o[0] ##[1:20] !sim[0]);
    c_trip: cover property (channel_active_o[0] ##1 !channel_active_o[0]
        && overcurrent_error_flag_o[0]);
    c_recover: cover property (overcurrent_error_flag_o[1] ##[1:50] channel_active_o[1]);
endmodule : laser_channel_regulation_config

// [testbench/host_model.sv]
// Host controller model that drives the register port
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // Released bus lines show the inverse, so nothing leans on a stale value
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        d = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
    endtask : read_reg

    // Source code 100 plus measure bit routes laser current to the converter
    task automatic select_current_measure(input int ch);
        write_reg(ch ? 8'h15 : 8'h10, 8'h80, 0);
        write_reg(8'h1a, ch ? 8'h20 : 8'h02, 2);
    endtask : select_current_measure
endmodule : host_model

// [testbench/laser_channel_regulation_config_tb_top.sv]
// Self-checking bench for the channel regulation configuration block
`timescale 1ns/1ps
module laser_channel_regulation_config_tb_top;
    localparam int W = laser_cfg_pkg::CUR_W;
    logic core_clk_i;
    logic rst_n_i;
    logic [7:0] addr, wdata, rdata, rv;
    logic wr, rd, chk_n;
    logic [1:0] pin, lin, creg, route, rlow, prot, flag, act, dlin, msel, mrdy;
    logic [1:0][9:0] refc, kn, dac;
    logic [1:0][W-1:0] cur, lim;
    logic [1:0][13:0] fsc;
    logic [1:0][2:0] src;
    int bad_count = 0;
    int n_tests = 0;
    int kt[4] = '{750, 100, 25, 9};
    int ft[8] = '{7500, 1000, 250, 90, 900, 120, 30, 11};

    host_model u_host (.core_clk_i(core_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));

    laser_channel_regulation_config #(.CUR_W(W)) u_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .channel_enable_pin_i(pin), .reference_coding_select_i(lin),
        .reference_code_i(refc), .laser_current_i(cur), .current_regulation_o(creg),
        .sense_resistor_route_o(route), .sense_range_low_o(rlow),
        .range_factor_num_o(kn), .full_scale_o(fsc), .threshold_limit_o(lim),
        .protection_active_o(prot), .overcurrent_error_flag_o(flag),
        .fault_check_output_n_o(chk_n), .channel_active_o(act), .dac_code_o(dac),
        .dac_linear_o(dlin), .converter_source_o(src), .current_measure_select_o(msel),
        .current_measure_ready_o(mrdy));

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.read_reg(a, rv);
        chk($sformatf("register %0h", a), {24'h0, exp}, {24'h0, rv});
    endtask : rchk

    task automatic settle();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask : settle

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // Reset values, unmapped place ignored, channels held off by the disable bit
    task automatic test_reset_values();
        u_host.write_reg(8'h40, 8'hff, 0);
        rchk(8'h40, 8'h00);
        rchk(8'h10, 8'h08);
        rchk(8'h11, 8'hff);
        rchk(8'h15, 8'h08);
        rchk(8'h16, 8'hff);
        rchk(8'h1a, 8'h00);
        rchk(8'h1d, 8'h00);
        rchk(8'h1e, 8'h00);
        chk("limit max", 32'(255 * 750 * 8), 32'(lim[0]));
        chk("active", 32'h0, 32'(act));
    endtask : test_reset_values

    task automatic test_ranges();
        for (int r = 0; r < 2; r++) begin
            for (int s = 0; s < 4; s++) begin
                u_host.write_reg(8'h1a, 8'(r | (r << 4)), 0);
                u_host.write_reg(8'h1e, 8'(s | (s << 4)), s);
                settle();
                for (int c = 0; c < 2; c++) begin
                    chk("range low", 32'(r), 32'(rlow[c]));
                    chk("k num", 32'(kt[s]), 32'(kn[c]));
                    chk("full scale", 32'(ft[r * 4 + s]), 32'(fsc[c]));
                    chk("limit", 32'(255 * kt[s] * (r ? 1 : 8)), 32'(lim[c]));
                end
            end
        end
    endtask : test_ranges

    task automatic test_mode_protection();
        u_host.write_reg(8'h10, 8'h01, 0);
        u_host.write_reg(8'h15, 8'h00, 0);
        settle();
        chk("current mode", 32'h1, 32'(creg));
        chk("sense route", 32'h1, 32'(route));
        rchk(8'h10, 8'h01);
        u_host.write_reg(8'h11, 8'h00, 0);
        u_host.write_reg(8'h16, 8'h00, 0);
        settle();
        chk("prot off zero", 32'h0, 32'(prot[0]));
        chk("prot min zero", 32'h1, 32'(prot[1]));
        chk("limit min", 32'h0, 32'(lim[1]));
        u_host.write_reg(8'h11, 8'h05, 0);
        lin = 2'b01;
        settle();
        chk("prot linear", 32'h0, 32'(prot[0]));
        lin = 2'b00;
        u_host.write_reg(8'h10, 8'h00, 0);
        settle();
        chk("prot log", 32'h1, 32'(prot[0]));
    endtask : test_mode_protection

    // Limit 1 * 9 units in low range; one unit above trips at the next edge
    task automatic test_trip();
        u_host.write_reg(8'h1a, 8'h01, 0);
        u_host.write_reg(8'h1e, 8'h03, 0);
        u_host.write_reg(8'h11, 8'h01, 0);
        settle();
        cur[0] = W'(9);
        settle();
        chk("no trip at limit", 32'h0, 32'(flag));
        chk("enabled", 32'h3, 32'(act));
        cur[0] = W'(10);
        @(posedge core_clk_i);
        #1;
        chk("trip flag", 32'h1, 32'(flag));
        chk("trip off", 32'h2, 32'(act));
        chk("check low", 32'h0, 32'(chk_n));
        cur[0] = W'(0);
        pin[0] = 1'b0;
        settle();
        chk("flag cleared", 32'h0, 32'(flag));
        pin[0] = 1'b1;
        settle();
        chk("re-enabled", 32'h3, 32'(act));
    endtask : test_trip

    task automatic test_sim();
        u_host.write_reg(8'h1d, 8'h60, 0);
        settle();
        chk("sim flag", 32'h3, 32'(flag));
        chk("sim off", 32'h0, 32'(act));
        chk("sim check", 32'h0, 32'(chk_n));
        rchk(8'h1d, 8'h60);
        repeat (20) @(posedge core_clk_i);
        #1;
        chk("sim held", 32'h3, 32'(flag));
        u_host.write_reg(8'h1d, 8'h20, 0);
        settle();
        chk("sim one released", 32'h1, 32'(flag));
        chk("sim one on", 32'h2, 32'(act));
        chk("check still low", 32'h0, 32'(chk_n));
        u_host.write_reg(8'h1d, 8'h00, 0);
        settle();
        chk("sim released", 32'h0, 32'(flag));
        chk("check high", 32'h1, 32'(chk_n));
        chk("back on", 32'h3, 32'(act));
    endtask : test_sim

    task automatic test_measure_ref();
        u_host.select_current_measure(1);
        settle();
        chk("source", 32'h4, 32'(src[1]));
        chk("measure sel", 32'h2, 32'(msel));
        chk("measure ready", 32'h2, 32'(mrdy));
        u_host.write_reg(8'h15, 8'h81, 0);
        settle();
        chk("ready in current mode", 32'h0, 32'(mrdy));
        refc = {10'h155, 10'h3ff};
        lin = 2'b10;
        settle();
        chk("ref code", 32'h557ff, 32'(dac));
        chk("ref linear", 32'h2, 32'(dlin));
    endtask : test_measure_ref

    initial begin
        rst_n_i = 1'b0;
        pin = 2'b11;
        lin = 2'b00;
        refc = '0;
        cur = '0;
        repeat (20) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
        settle();
        test_reset_values();
        test_ranges();
        test_mode_protection();
        test_trip();
        test_sim();
        test_measure_ref();
        test_done();
    end

    // About 185 cycles are expected; the limit leaves wide margin
    initial begin
        #200us;
        bad_count++;
        test_done();
    end
endmodule : laser_channel_regulation_config_tb_top
